/* rtl/inverse_delay_calc.sv */
// inverse-time delay arithmetic: power, sum and serial divide
`timescale 1ns/100ps
module inverse_delay_calc (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          srst,
    // curve inputs
    input  wire logic [31:0]                   ratio,
    input  wire logic                          series,
    input  wire trip_timer_pkg::const_t        constA,
    input  wire trip_timer_pkg::const_t        constB,
    input  wire trip_timer_pkg::const_t        constC,
    input  wire logic [trip_timer_pkg::DIAL_W-1:0] dial,
    // result in ms
    output logic [31:0]                        delayMs
);
    import trip_timer_pkg::*;

    // piecewise-linear log2 of a q16.16 value at or above 1.0
    function automatic logic [20:0] log2Fix(input logic [31:0] v);
        logic [4:0]  n;
        logic [31:0] s;
        n = 5'h10;
        for (int i = 16; i < 32; i++) begin
            if (v[i]) n = 5'(i);
        end
        s = v << (5'h1F - n);
        return {5'(n - 5'h10), s[30:15]};
    endfunction

    // piecewise-linear 2^x, saturating at the top of q16.16
    function automatic logic [31:0] exp2Fix(input logic [55:0] x);
        if (x[55:20] != 36'h0 || x[19:16] > 4'hE) return 32'hFFFF_FFFF;
        return {15'h0, 1'b1, x[15:0]} << x[19:16];
    endfunction

    logic [31:0] ratioClip;
    logic [21:0] expo;
    logic [55:0] scaled;
    logic [31:0] pwr;
    logic [31:0] den;
    logic [63:0] num;
    logic [41:0] denK;
    assign ratioClip = (ratio < PICKUP_RATIO) ? PICKUP_RATIO : ratio;
    assign expo = series ? constC : constB;
    // divide by 10000 as multiply by 6711 / 2^26
    assign scaled = 56'((34'(log2Fix(ratioClip) * expo) * 13'h1A37) >> 26);
    assign pwr = exp2Fix(scaled);
    assign den = series ? pwr - PICKUP_RATIO : pwr;
    // ms = (kA*2^16 + kB*den) / (den*1000); the B term only for family 2
    assign num = 64'({34'(dial * constA), 16'h0})
               + (series ? 64'(34'(dial * constB) * den) : 64'h0);
    assign denK = 42'(den * 10'h3E8);

    logic [63:0] quot_q;
    logic [48:0] rem_q;
    logic [41:0] denK_q;
    logic [6:0]  cnt_q;
    logic [48:0] remSh;
    assign remSh = {rem_q[47:0], quot_q[63]};

    // restoring divider, 64 steps, restarted on fresh inputs each pass
    always_ff @(posedge clk) begin
        if (srst || cnt_q == 7'h40) begin
            quot_q <= num;
            rem_q  <= 49'h0;
            denK_q <= denK;
            cnt_q  <= 7'h0;
        end else begin
            cnt_q <= cnt_q + 7'h1;
            if (remSh >= {7'h0, denK_q}) begin
                rem_q  <= remSh - {7'h0, denK_q};
                quot_q <= {quot_q[62:0], 1'b1};
            end else begin
                rem_q  <= remSh;
                quot_q <= {quot_q[62:0], 1'b0};
            end
        end
    end

    // a zero denominator means the curve never trips: saturate
    always_ff @(posedge clk) begin
        if (srst) begin
            delayMs <= 32'hFFFF_FFFF;
        end else if (cnt_q == 7'h40) begin
            if (denK_q == 42'h0 || quot_q[63:32] != 32'h0) begin
                delayMs <= 32'hFFFF_FFFF;
            end else begin
                delayMs <= quot_q[31:0];
            end
        end
    end
endmodule

/* rtl/protection_trip_delay_timer.sv */
// operating-time logic of a protection stage with APB settings
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Functional notes
// - start only when pick-up activates with blocking inactive
// - pick-up drops out only below 97 percent of the setting; DROP_RATIO drops below 96 percent
// - definite mode trips after the set delay while picked up
// - inverse mode delay falls as measured-to-setting ratio rises
// - in inverse mode definite delay is a floor; zero removes it
// - selector picks definite or inverse; resets to definite
// - definite delay in 5 ms steps up to 1800 s, default 40 ms
// - zero definite delay trips together with start
// - series selector picks curve family, first by default
// - first family: normal, extreme, very, long-time, custom A/B
// - second family: seven standard curves plus custom A/B/C
// - dial scales inverse curves, 0.01 steps to 25, default 0.05
// - constant A, 0.0001 steps, default 0.0860, custom only
// - constant B, 0.0001 steps up to 5, default 0.1850
// - constant C, 0.0001 steps, default 0.0200, second family
// - second family delay is k times (A over (r^C minus 1) plus B)
module protection_trip_delay_timer #(
    parameter int TICK_DIV = trip_timer_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // measurement and blocking
    input  wire logic [31:0] ratio,
    input  wire logic        blockIn,
    // stage outputs
    output logic             pickupOut,
    output logic             startOut,
    output logic             tripOut,
    output logic             blockedOut,
    output logic             releaseOut
);
    import trip_timer_pkg::*;

    // clamp a written value to its legal ceiling
    function automatic logic [31:0] clampTo(input logic [31:0] v,
                                            input logic [31:0] lim);
        return (v > lim) ? lim : v;
    endfunction

    // settings
    delay_mode_t         mode_q;
    logic                series_q;
    logic [2:0]          curve_q;
    logic [DEF_W-1:0]    defDly_q;
    logic [DIAL_W-1:0]   dial_q;
    const_t              constA_q;
    logic [B_W-1:0]      constB_q;
    const_t              constC_q;
    // timer state
    timer_state_t        state_q;
    timer_state_t        state_d;
    logic [31:0]         elapsed_q;
    logic [31:0]         tickCnt_q;
    logic                tick;
    logic [31:0]         invDelay;

    // apb decode
    logic setupPh;
    logic wrEn;
    logic hitCtrl;
    logic hitDef;
    logic hitDial;
    logic hitA;
    logic hitB;
    logic hitC;
    logic hitStat;
    logic hitDly;
    logic hitElap;
    logic mapped;
    assign setupPh = psel && !penable;
    assign wrEn    = psel && penable && pready && pwrite;
    assign hitCtrl = paddr == CTRL_OFF;
    assign hitDef  = paddr == DEFDLY_OFF;
    assign hitDial = paddr == DIAL_OFF;
    assign hitA    = paddr == CONSTA_OFF;
    assign hitB    = paddr == CONSTB_OFF;
    assign hitC    = paddr == CONSTC_OFF;
    assign hitStat = paddr == STATUS_OFF;
    assign hitDly  = paddr == DELAY_OFF;
    assign hitElap = paddr == ELAPSED_OFF;
    assign mapped  = hitCtrl | hitDef | hitDial | hitA | hitB | hitC
                   | hitStat | hitDly | hitElap;

    // curve choice; custom constants apply only to the custom option
    logic        isCustom;
    logic [3:0]  curveIdx;
    const_t      effA;
    const_t      effB;
    const_t      effC;
    logic [31:0] defMs;
    logic [31:0] target;
    logic        pickupNow;
    logic        dueNow;
    assign isCustom = series_q ? (curve_q == FAM2_CUSTOM)
                               : (curve_q >= FAM1_CUSTOM);
    assign curveIdx = series_q ? 4'(curve_q) + 4'h4 : {2'h0, curve_q[1:0]};
    assign effA = isCustom ? constA_q : CURVES[curveIdx][0];
    assign effB = isCustom ? K_W'(constB_q) : CURVES[curveIdx][1];
    assign effC = isCustom ? constC_q : CURVES[curveIdx][2];

    // power, sum and divide run continuously on the live ratio
    inverse_delay_calc inverse_delay_calc_inst (
        .clk     (clk),
        .srst    (srst),
        .ratio   (ratio),
        .series  (series_q),
        .constA  (effA),
        .constB  (effB),
        .constC  (effC),
        .dial    (dial_q),
        .delayMs (invDelay)
    );

    // definite delay is held in 5 ms steps
    assign defMs = 32'(defDly_q * DEF_STEP_MS);
    // inverse result never beats the definite floor; zero floor is none
    assign target = (mode_q == inverse_curve_mode && invDelay > defMs)
                  ? invDelay : defMs;
    assign dueNow = elapsed_q >= target;

    // hysteresis: pick up at 1.0, drop only under 0.96
    assign pickupNow = pickupOut ? (ratio >= DROP_RATIO)
                                 : (ratio >= PICKUP_RATIO);

    // register writes, values clamped to their documented range
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q   <= definite_delay_mode;
            series_q <= 1'b0;
            curve_q  <= normal_inverse_curve;
            defDly_q <= DEF_RST;
            dial_q   <= DIAL_RST;
            constA_q <= A_RST;
            constB_q <= B_RST;
            constC_q <= C_RST;
        end else if (wrEn) begin
            if (hitCtrl) begin
                mode_q   <= delay_mode_t'(pwdata[MODE_BIT]);
                series_q <= pwdata[SERIES_BIT];
                curve_q  <= pwdata[CURVE_LSB+:3];
            end
            if (hitDef) begin
                defDly_q <= DEF_W'(clampTo(pwdata, 32'(DEF_MAX)));
            end
            if (hitDial) begin
                dial_q <= DIAL_W'(clampTo(pwdata, 32'(DIAL_MAX)));
            end
            if (hitA) begin
                constA_q <= K_W'(clampTo(pwdata, 32'(K_MAX)));
            end
            if (hitB) begin
                constB_q <= B_W'(clampTo(pwdata, 32'(B_MAX)));
            end
            if (hitC) begin
                constC_q <= K_W'(clampTo(pwdata, 32'(K_MAX)));
            end
        end
    end

    // read mux
    logic [31:0] rdMux;
    assign rdMux = hitCtrl ? {25'h0, curve_q, 2'h0, series_q, mode_q}
                 : hitDef  ? 32'(defDly_q)
                 : hitDial ? 32'(dial_q)
                 : hitA    ? 32'(constA_q)
                 : hitB    ? 32'(constB_q)
                 : hitC    ? 32'(constC_q)
                 : hitStat ? {26'h0, state_q, blockedOut, tripOut,
                              startOut, pickupOut}
                 : hitDly  ? target
                 : hitElap ? elapsed_q
                 : 32'h0;

    // no wait state; read data is registered in the setup phase
    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (setupPh) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= pwrite ? 32'h0 : rdMux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // 1 ms tick; restarts with each new timing run for fair counting
    assign tick = tickCnt_q == 32'(TICK_DIV - 1);
    always_ff @(posedge clk) begin
        if (srst || tick || state_q == ST_IDLE) begin
            tickCnt_q <= 32'h0;
        end else begin
            tickCnt_q <= tickCnt_q + 32'h1;
        end
    end

    // elapsed time since start, in ms
    always_ff @(posedge clk) begin
        if (srst || state_q != ST_TIMING) begin
            elapsed_q <= 32'h0;
        end else if (tick && elapsed_q != 32'hFFFF_FFFF) begin
            elapsed_q <= elapsed_q + 32'h1;
        end
    end

    // next state of the operating timer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (pickupNow && !blockIn) begin
                    state_d = (target == 32'h0) ? ST_TRIP
                                                : ST_TIMING;
                end
            end
            ST_TIMING: begin
                if (!pickupNow || blockIn) begin
                    state_d = ST_IDLE;
                end else if (dueNow) begin
                    state_d = ST_TRIP;
                end
            end
            ST_TRIP: begin
                if (!pickupNow || blockIn) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state and registered stage outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q    <= ST_IDLE;
            pickupOut  <= 1'b0;
            startOut   <= 1'b0;
            tripOut    <= 1'b0;
            blockedOut <= 1'b0;
            releaseOut <= 1'b0;
        end else begin
            state_q    <= state_d;
            pickupOut  <= pickupNow;
            startOut   <= state_d != ST_IDLE;
            tripOut    <= state_d == ST_TRIP;
            blockedOut <= pickupNow && blockIn;
            // release handling is told when a run ends without trip
            releaseOut <= state_q == ST_TIMING
                       && state_d == ST_IDLE;
        end
    end
endmodule

/* rtl/trip_timer_pkg.sv */
// constants, types and register map of the trip delay timer
package trip_timer_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF    = 8'h00;
    localparam logic [7:0] DEFDLY_OFF  = 8'h04;
    localparam logic [7:0] DIAL_OFF    = 8'h08;
    localparam logic [7:0] CONSTA_OFF  = 8'h0C;
    localparam logic [7:0] CONSTB_OFF  = 8'h10;
    localparam logic [7:0] CONSTC_OFF  = 8'h14;
    localparam logic [7:0] STATUS_OFF  = 8'h18;
    localparam logic [7:0] DELAY_OFF   = 8'h1C;
    localparam logic [7:0] ELAPSED_OFF = 8'h20;
    // control field positions
    localparam int MODE_BIT   = 0;
    localparam int SERIES_BIT = 1;
    localparam int CURVE_LSB  = 4;
    // widths
    localparam int DEF_W = 19;
    localparam int DIAL_W = 12;
    localparam int K_W = 22;
    localparam int B_W = 16;
    // reset values and limits (units: 5 ms, 0.01, 0.0001)
    localparam logic [DEF_W-1:0]  DEF_RST   = 19'h00008;
    localparam logic [DEF_W-1:0]  DEF_MAX   = 19'h57E40;
    localparam logic [DIAL_W-1:0] DIAL_RST  = 12'h005;
    localparam logic [DIAL_W-1:0] DIAL_MAX  = 12'h9C4;
    localparam logic [K_W-1:0]    A_RST     = 22'h00035C;
    localparam logic [K_W-1:0]    K_MAX     = 22'h2625A0;
    localparam logic [B_W-1:0]    B_RST     = 16'h073A;
    localparam logic [B_W-1:0]    B_MAX     = 16'hC350;
    localparam logic [K_W-1:0]    C_RST     = 22'h0000C8;
    // definite step is 5 ms of timer ticks
    localparam logic [2:0] DEF_STEP_MS = 3'h5;
    // pick-up on ratio >= 1.0, drop below 0.96 (q16.16)
    localparam logic [31:0] PICKUP_RATIO = 32'h0001_0000;
    localparam logic [31:0] DROP_RATIO   = 32'h0000_F5C3;
    // timer tick: 1 ms at 250 MHz
    localparam int TICK_MS = 1;
    localparam int CLK_KHZ = 250000;
    localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_TIMING = 2'b01,
        ST_TRIP   = 2'b10
    } timer_state_t;
    typedef enum logic [0:0] {
        definite_delay_mode = 1'b0,
        inverse_curve_mode  = 1'b1
    } delay_mode_t;
    // curve codes: first family 0..3, 4 custom; second 0..6, 7 custom
    localparam logic [2:0] normal_inverse_curve = 3'h0;
    localparam logic [2:0] FAM1_CUSTOM = 3'h4;
    localparam logic [2:0] FAM2_CUSTOM = 3'h7;
    typedef logic [K_W-1:0] const_t;
    // standard curve constants, 0.0001 units: {A, B, C}
    typedef const_t curve_tab_t [12][3];
    localparam curve_tab_t CURVES = '{
        '{22'h00578, 22'h000C8, 22'h00000},   // first normal
        '{22'hC3500, 22'h04E20, 22'h00000},   // first extreme
        '{22'h20F58, 22'h02710, 22'h00000},   // first very
        '{22'h124F80,22'h02710, 22'h00000},   // first long-time
        '{22'h15CFC, 22'h00705, 22'h051CC},   // second normal
        '{22'h09934, 22'h003D6, 22'h04E20},   // second very
        '{22'h0DC50, 22'h000F3, 22'h04E20},   // second extreme
        '{22'h0DB4C, 22'h05564, 22'h02710},   // second long-time
        '{22'h00203, 22'h00474, 22'h000C8},   // moderate
        '{22'h2FE04, 22'h0132E, 22'h04E20},   // other very
        '{22'h44D90, 22'h004C1, 22'h04E20},   // other extreme
        '{22'h00000, 22'h00000, 22'h00000}
    };
endpackage

/* testbench/protection_trip_delay_timer_checker.sv */
// port-level assertions for the trip delay timer
`timescale 1ns/100ps
module protection_trip_delay_timer_checker
    import trip_timer_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // stage
    input wire logic [31:0] ratio,
    input wire logic        blockIn,
    input wire logic        pickupOut,
    input wire logic        startOut,
    input wire logic        tripOut,
    input wire logic        blockedOut,
    input wire logic        releaseOut
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_up; $rose(pickupOut) |-> $past(ratio) >= PICKUP_RATIO;
    endproperty
    a_up: assert property (p_up) else $error("pick-up too low");
    property p_dn; $fell(pickupOut) |-> $past(ratio) < DROP_RATIO;
    endproperty
    a_dn: assert property (p_dn) else $error("early drop");
    property p_st; $rose(startOut) |-> !$past(blockIn); endproperty
    a_st: assert property (p_st) else $error("start while blocked");
    property p_bk; startOut && blockIn |=> !startOut; endproperty
    a_bk: assert property (p_bk) else $error("run kept blocked");
    property p_bo; blockedOut |-> $past(blockIn) || $past(blockIn, 2);
    endproperty
    a_bo: assert property (p_bo) else $error("blocked flag");
    property p_tr; tripOut |-> startOut; endproperty
    a_tr: assert property (p_tr) else $error("trip without start");
    property p_sp; $fell(pickupOut) |-> ##[0:1] !startOut; endproperty
    a_sp: assert property (p_sp) else $error("timer not stopped");
    property p_rl; releaseOut |-> !$past(tripOut) ##1 !releaseOut;
    endproperty
    a_rl: assert property (p_rl) else $error("bad release");
endmodule

bind protection_trip_delay_timer protection_trip_delay_timer_checker
    checker_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .ratio(ratio), .blockIn(blockIn),
    .pickupOut(pickupOut), .startOut(startOut), .tripOut(tripOut),
    .blockedOut(blockedOut), .releaseOut(releaseOut));

/* testbench/protection_trip_delay_timer_tb.sv */
// self-checking bench of the trip delay timer
`timescale 1ns/100ps
`define CHK(nm, ex, sn) begin checks++; if ((sn) !== (ex)) begin \
    n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, ex, sn); end end
module protection_trip_delay_timer_tb;
    import trip_timer_pkg::*;
    // short tick keeps the millisecond timer fast
    localparam int TD = 8;
    logic        clk     = 1'b0;
    logic        srst    = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        blockIn = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] ratio   = 32'h0;
    logic [31:0] prdata, rd, d1;
    logic        pready, pslverr, pickupOut, startOut;
    logic        tripOut, blockedOut, releaseOut, er;
    int          n_fail  = 0;
    int          checks  = 0;
    int          n;
    always #2 clk = ~clk;
    protection_trip_delay_timer #(.TICK_DIV(TD)) protection_trip_delay_timer_inst (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ratio(ratio),
        .blockIn(blockIn), .pickupOut(pickupOut), .startOut(startOut),
        .tripOut(tripOut), .blockedOut(blockedOut), .releaseOut(releaseOut)
    );
    task stop_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task tmo();
        n_fail++;
        stop_test();
    endtask
    // one apb transfer; entered right after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) tmo();
        // idle edge so a following call never reassigns psel this step
        @(posedge clk);
    endtask
    // bounded wait for start (0), trip (1) or release (2)
    task wait_for(input int s, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((s == 0 ? startOut : s == 1 ? tripOut : releaseOut)
                   !== 1'b1 && n < lim);
        if (n >= lim) tmo();
    endtask
    task idle();
        ratio <= 32'h0;
        blockIn <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task t_reset();
        logic [7:0]  ra [6];
        logic [31:0] rv [6];
        ra = '{CTRL_OFF, DEFDLY_OFF, DIAL_OFF, CONSTA_OFF, CONSTB_OFF,
               CONSTC_OFF};
        rv = '{32'h0, 32'h8, 32'h5, 32'h35C, 32'h73A, 32'hC8};
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ra[i], 32'h0);
            `CHK("reset value", rv[i], rd)
        end
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        apb(1'b1, STATUS_OFF, 32'hFF);
        apb(1'b0, STATUS_OFF, 32'h0);
        `CHK("read-only", 32'h0, rd)
        apb(1'b1, DEFDLY_OFF, 32'hFFFFFFFF);
        apb(1'b0, DEFDLY_OFF, 32'h0);
        `CHK("delay ceiling", 32'h57E40, rd)
        apb(1'b1, CONSTB_OFF, 32'hFFFFFFFF);
        apb(1'b0, CONSTB_OFF, 32'h0);
        `CHK("b ceiling", 32'hC350, rd)
    endtask
    // definite time at two magnitudes: same 10 ms either way
    task t_def(input logic [31:0] r);
        apb(1'b1, DEFDLY_OFF, 32'h2);
        ratio <= r;
        wait_for(0, 20);
        wait_for(1, 200);
        `CHK("dt time", 1'b1, n >= 10 * TD && n <= 10 * TD + 2)
        apb(1'b0, DELAY_OFF, 32'h0);
        `CHK("dt target", 32'hA, rd)
        ratio <= 32'h0000_F800;
        repeat (4) @(posedge clk);
        `CHK("hysteresis", 1'b1, tripOut)
        idle();
        `CHK("trip off", 1'b0, tripOut)
    endtask
    task t_zero();
        apb(1'b1, DEFDLY_OFF, 32'h0);
        ratio <= 32'h0003_0000;
        wait_for(0, 20);
        `CHK("instant trip", 1'b1, tripOut)
        idle();
    endtask
    // drop out mid-run and block mid-run, both without trip
    task t_abort(input logic blk);
        apb(1'b1, DEFDLY_OFF, 32'h8);
        ratio <= 32'h0002_0000;
        wait_for(0, 20);
        repeat (100) @(posedge clk);
        if (blk) blockIn <= 1'b1;
        else ratio <= 32'h0;
        wait_for(2, 10);
        `CHK("no trip", 1'b0, tripOut)
        repeat (2) @(posedge clk);
        `CHK("stopped", 1'b0, startOut)
        idle();
    endtask
    task t_block();
        blockIn <= 1'b1;
        ratio <= 32'h0002_0000;
        repeat (5) @(posedge clk);
        `CHK("blocked", 1'b1, blockedOut)
        `CHK("no start", 1'b0, startOut)
        idle();
    endtask
    // curve target at ratio 2 within a tenth, then lower at ratio 5
    task t_inv(input logic s, input int e);
        apb(1'b1, DEFDLY_OFF, 32'h0);
        apb(1'b1, CTRL_OFF, {30'h0, s, 1'b1});
        ratio <= 32'h0002_0000;
        repeat (200) @(posedge clk);
        apb(1'b0, DELAY_OFF, 32'h0);
        d1 = rd;
        `CHK("curve", 1'b1, d1 >= e - e / 10 && d1 <= e + e / 10)
        ratio <= 32'h0005_0000;
        repeat (200) @(posedge clk);
        apb(1'b0, DELAY_OFF, 32'h0);
        `CHK("falling delay", 1'b1, rd < d1)
        idle();
    endtask
    // 1 s floor over a few-ms first-family curve, then no floor
    task t_floor(input logic [31:0] f);
        apb(1'b1, DEFDLY_OFF, f);
        ratio <= 32'h0005_0000;
        wait_for(0, 20);
        wait_for(1, 9000);
        `CHK("floor", f != 0, n >= 1000 * TD)
        idle();
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_def(32'h0002_0000);
        t_def(32'h0008_0000);
        t_zero();
        t_abort(1'b0);
        t_abort(1'b1);
        t_block();
        // first family is kA/r^B: dial 25 gives 3.5 s / 2^0.02, 3452 ms
        apb(1'b1, DIAL_OFF, 32'h9C4);
        t_inv(1'b0, 3452);
        apb(1'b1, DIAL_OFF, 32'h5);
        t_inv(1'b1, 146);
        apb(1'b1, CTRL_OFF, 32'h1);
        t_floor(32'hC8);
        t_floor(32'h0);
        stop_test();
    end
endmodule
